//--- hdl/tml_map.svh
// Constants of the transceiver mode latch: widths, field positions, codes, reset values
`ifndef TML_MAP_SVH
`define TML_MAP_SVH

// Serial word and latch widths
`define TML_WORD_W            20
`define TML_MODE_W            18
`define TML_SEL_W             2

// Position of the latch select bit inside the serial word
`define TML_WORD_LATCH_SEL    0
// Select codes (bit 1 = high select bit, bit 0 = low select bit)
`define TML_SEL_FEEDBACK      2'h0
`define TML_SEL_REFERENCE     2'h2

// Field positions inside the mode latch (mode bit n sits at index n-1)
`define TML_MB_PRESCALER      0
`define TML_MB_POLARITY       1
`define TML_MB_PUMP_GAIN      2
`define TML_MB_PUMP_HIGH_Z    3
`define TML_MB_RESERVED       4
`define TML_MB_RX_SW_OFF      5
`define TML_MB_TX_SW_OFF      6
`define TML_MB_GP0            7
`define TML_MB_GP1            8
`define TML_MB_GP2            9
`define TML_MB_PD_LOW         10
`define TML_MB_PD_HIGH        11
`define TML_MB_DEMOD_GAIN     12
`define TML_MB_SHIFT_SIGN     13
`define TML_MB_SHIFT_ONE      14
`define TML_MB_SHIFT_HALF     15
`define TML_MB_SHIFT_QUARTER  16
`define TML_MB_SHIFT_EIGHTH   17

// Reset values
`define TML_MODE_RESET        18'h00000
`define TML_WORD_RESET        20'h00000

// Number of pins that pass the input filter
`define TML_PIN_COUNT         7

`endif

//--- hdl/tml_mode_latch.sv
// Serial input register, mode latch and power-down decoding of the transceiver
// Functional notes
// - Select bit 0 set: word bits 19..2 load latch
// - Prescaler modulus and pump gain from mode bits
// - Mode bit 2 sets detector polarity
// - Mode bit 4 forces pump high impedance
// - Software chain power-down in software and test modes
// - Output 0 always; outputs 1,2 software mode only
// - Bits 11,12 select software or hardwire control
// - Hardwire mode: chains follow their pins, high on
// - PLL pin high stops; chip enable low off
// - Demodulator gain, shift sign and shift weights
// - Shift 20 bits MSB first on clock rise
// - Strobe rise moves word to addressed register
// - Divider selects leave the mode latch unchanged
`timescale 1ns/100ps
`default_nettype none
`include "tml_map.svh"
module tml_mode_latch (
  input  wire logic        clock_i,
  input  wire logic        rst_i,
  input  wire logic        serial_clock_i,
  input  wire logic        serial_data_i,
  input  wire logic        load_strobe_i,
  input  wire logic        chip_enable_i,
  input  wire logic        receive_shutdown_pin_i,
  input  wire logic        transmit_shutdown_pin_i,
  input  wire logic        synth_shutdown_pin_i,
  output logic             prescaler_modulus_sel_o,
  output logic             detector_polarity_sel_o,
  output logic             pump_gain_sel_o,
  output logic             pump_high_z_o,
  output logic             reserved_zero_bit_o,
  output logic [2:0]       gp_out_o,
  output logic             pd_hardwire_o,
  output logic             pd_test_mode_o,
  output logic             rx_chain_on_o,
  output logic             tx_chain_on_o,
  output logic             synth_on_o,
  output logic             chip_on_o,
  output logic             demod_gain_sel_o,
  output logic             demod_shift_sign_o,
  output logic [3:0]       demod_shift_code_o,
  output logic [17:0]      mode_word_o,
  output logic [17:0]      divider_word_o,
  output logic             feedback_load_o,
  output logic             reference_load_o
);

  ////////////////////////////////////////////////////////////////////////////////
  // Pin filtering

  logic [`TML_PIN_COUNT-1:0] pin_raw;
  logic [`TML_PIN_COUNT-1:0] pin_lvl;

  // Every pin is asynchronous to clock_i; all share one delay so data keeps its setup to clock
  assign pin_raw = {synth_shutdown_pin_i, transmit_shutdown_pin_i, receive_shutdown_pin_i,
                    chip_enable_i, load_strobe_i, serial_data_i, serial_clock_i};

  tml_sync #(
    .W (`TML_PIN_COUNT)
  ) u_sync (
    .clock_i (clock_i),
    .rst_i   (rst_i),
    .async_i (pin_raw),
    .level_o (pin_lvl)
  );

  logic sclk_lvl;
  logic sdata_lvl;
  logic strobe_lvl;
  logic ce_lvl;
  logic rx_pin_lvl;
  logic tx_pin_lvl;
  logic pll_pin_lvl;

  assign sclk_lvl    = pin_lvl[0];
  assign sdata_lvl   = pin_lvl[1];
  assign strobe_lvl  = pin_lvl[2];
  assign ce_lvl      = pin_lvl[3];
  assign rx_pin_lvl  = pin_lvl[4];
  assign tx_pin_lvl  = pin_lvl[5];
  assign pll_pin_lvl = pin_lvl[6];

  ////////////////////////////////////////////////////////////////////////////////
  // State

  tml_pkg::tml_state_t st_q;
  tml_pkg::tml_state_t st_d;

  logic                sclk_rise;
  logic                strobe_rise;
  logic [`TML_SEL_W-1:0] sel;
  tml_pkg::tml_mode_t  m;

  assign sclk_rise   = sclk_lvl & ~st_q.sclk_prev;
  assign strobe_rise = strobe_lvl & ~st_q.strobe_prev;
  assign sel         = st_q.shift[`TML_SEL_W-1:0];

  // Next state: shifting, loading and registered decode of the latch and pins
  always_comb begin
    st_d                = st_q;
    st_d.sclk_prev      = sclk_lvl;
    st_d.strobe_prev    = strobe_lvl;
    st_d.feedback_load  = 1'b0;
    st_d.reference_load = 1'b0;

    // Shift in on each serial clock rise, first bit ends up at the top
    if (sclk_rise) begin
      st_d.shift = {st_q.shift[`TML_WORD_W-2:0], sdata_lvl};
    end

    // Strobe rise hands the word to the register picked by the two lowest bits
    if (strobe_rise) begin
      if (st_q.shift[`TML_WORD_LATCH_SEL]) begin
        st_d.mode = st_q.shift[`TML_WORD_W-1:`TML_SEL_W];
      end else if (sel == `TML_SEL_FEEDBACK) begin
        st_d.feedback_load = 1'b1;
        st_d.divider_word  = st_q.shift[`TML_WORD_W-1:`TML_SEL_W];
      end else begin
        st_d.reference_load = 1'b1;
        st_d.divider_word   = st_q.shift[`TML_WORD_W-1:`TML_SEL_W];
      end
    end

    // Decode works from the latch contents, so shifting alone never moves an output
    m = st_d.mode;

    // Mixed select codes are test settings; control then stays with software bits
    unique case ({m[`TML_MB_PD_HIGH], m[`TML_MB_PD_LOW]})
      2'h0: st_d.pd_mode = tml_pkg::TML_PD_SOFT;
      2'h3: st_d.pd_mode = tml_pkg::TML_PD_HARD;
      default: st_d.pd_mode = tml_pkg::TML_PD_TEST;
    endcase

    st_d.chip_on = ce_lvl;
    st_d.pll_on  = ce_lvl & ~pll_pin_lvl;

    if (st_d.pd_mode == tml_pkg::TML_PD_HARD) begin
      st_d.rx_on = ce_lvl & rx_pin_lvl;
      st_d.tx_on = ce_lvl & tx_pin_lvl;
    end else begin
      st_d.rx_on = ce_lvl & ~m[`TML_MB_RX_SW_OFF];
      st_d.tx_on = ce_lvl & ~m[`TML_MB_TX_SW_OFF];
    end

    // Outputs 1 and 2 are parked low whenever software control is not selected
    st_d.gp_out[0] = m[`TML_MB_GP0];
    if (st_d.pd_mode == tml_pkg::TML_PD_SOFT) begin
      st_d.gp_out[1] = m[`TML_MB_GP1];
      st_d.gp_out[2] = m[`TML_MB_GP2];
    end else begin
      st_d.gp_out[1] = 1'b0;
      st_d.gp_out[2] = 1'b0;
    end
  end

  // State register
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      st_q.sclk_prev      <= 1'b0;
      st_q.strobe_prev    <= 1'b0;
      st_q.shift          <= `TML_WORD_RESET;
      st_q.mode           <= `TML_MODE_RESET;
      st_q.pd_mode        <= tml_pkg::TML_PD_SOFT;
      st_q.feedback_load  <= 1'b0;
      st_q.reference_load <= 1'b0;
      st_q.divider_word   <= `TML_MODE_RESET;
      st_q.rx_on          <= 1'b0;
      st_q.tx_on          <= 1'b0;
      st_q.pll_on         <= 1'b0;
      st_q.chip_on        <= 1'b0;
      st_q.gp_out         <= 3'h0;
    end else begin
      st_q <= st_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs, all straight from the state register

  // Synthesizer controls
  assign prescaler_modulus_sel_o = st_q.mode[`TML_MB_PRESCALER];
  assign pump_gain_sel_o         = st_q.mode[`TML_MB_PUMP_GAIN];
  assign detector_polarity_sel_o = st_q.mode[`TML_MB_POLARITY];
  assign pump_high_z_o           = st_q.mode[`TML_MB_PUMP_HIGH_Z];
  // Shown so a bench can see a host that breaks the zero convention
  assign reserved_zero_bit_o     = st_q.mode[`TML_MB_RESERVED];

  // Power-down results
  assign pd_hardwire_o  = (st_q.pd_mode == tml_pkg::TML_PD_HARD);
  assign pd_test_mode_o = (st_q.pd_mode == tml_pkg::TML_PD_TEST);
  assign rx_chain_on_o  = st_q.rx_on;
  assign tx_chain_on_o  = st_q.tx_on;
  assign synth_on_o     = st_q.pll_on;
  assign chip_on_o      = st_q.chip_on;
  assign gp_out_o       = st_q.gp_out;

  // Demodulator: shift code counts in steps of one eighth of a volt
  assign demod_gain_sel_o   = st_q.mode[`TML_MB_DEMOD_GAIN];
  assign demod_shift_sign_o = st_q.mode[`TML_MB_SHIFT_SIGN];
  assign demod_shift_code_o = {st_q.mode[`TML_MB_SHIFT_ONE], st_q.mode[`TML_MB_SHIFT_HALF],
                               st_q.mode[`TML_MB_SHIFT_QUARTER],
                               st_q.mode[`TML_MB_SHIFT_EIGHTH]};

  // Raw words and divider load pulses for the counters outside this block
  assign mode_word_o      = st_q.mode;
  assign divider_word_o   = st_q.divider_word;
  assign feedback_load_o  = st_q.feedback_load;
  assign reference_load_o = st_q.reference_load;

endmodule
`default_nettype wire

//--- hdl/tml_pkg.sv
// Types shared by the transceiver mode latch design
package tml_pkg;
  `include "tml_map.svh"

  typedef logic [`TML_MODE_W-1:0] tml_mode_t;
  typedef logic [`TML_WORD_W-1:0] tml_word_t;

  // Power-down control source decoded from the two mode select bits
  typedef enum logic [2:0] {
    TML_PD_SOFT = 3'h1,
    TML_PD_HARD = 3'h2,
    TML_PD_TEST = 3'h4
  } tml_pd_mode_t;

  // Whole state of the latch block
  typedef struct packed {
    logic         sclk_prev;
    logic         strobe_prev;
    tml_word_t    shift;
    tml_mode_t    mode;
    tml_pd_mode_t pd_mode;
    logic         feedback_load;
    logic         reference_load;
    logic [`TML_MODE_W-1:0] divider_word;
    logic         rx_on;
    logic         tx_on;
    logic         pll_on;
    logic         chip_on;
    logic [2:0]   gp_out;
  } tml_state_t;
endpackage

//--- hdl/tml_sync.sv
// Three-stage input filter for asynchronous pins
`timescale 1ns/100ps
`default_nettype none
module tml_sync #(
  parameter int W = 1
) (
  input  wire logic         clock_i,
  input  wire logic         rst_i,
  input  wire logic [W-1:0] async_i,
  output logic      [W-1:0] level_o
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] lvl;
  } tml_sync_state_t;

  tml_sync_state_t st_q;
  tml_sync_state_t st_d;

  // Stage one feeds only stage two; the filtered level moves where stages two and three agree
  always_comb begin
    st_d     = st_q;
    st_d.s1  = async_i;
    st_d.s2  = st_q.s1;
    st_d.s3  = st_q.s2;
    st_d.lvl = (st_q.s2 & st_q.s3) | (st_q.lvl & (st_q.s2 ^ st_q.s3));
  end

  // State register
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign level_o = st_q.lvl;

endmodule
`default_nettype wire

//--- verif/tb_top.sv
// Bench that loads mode words and drives the control pins
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  logic        clock_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        chip_enable_i = 1'b1;
  logic        receive_shutdown_pin_i = 1'b0;
  logic        transmit_shutdown_pin_i = 1'b0;
  logic        synth_shutdown_pin_i = 1'b0;
  wire logic   serial_clock_i;
  wire logic   serial_data_i;
  wire logic   load_strobe_i;
  logic [17:0] mode_word_o;
  logic [17:0] divider_word_o;
  logic [2:0]  gp_out_o;
  logic        rx_chain_on_o, tx_chain_on_o, synth_on_o, chip_on_o;
  logic        feedback_load_o, reference_load_o;
  logic [3:0]  demod_shift_code_o;
  logic        prescaler_modulus_sel_o, detector_polarity_sel_o, pump_gain_sel_o;
  logic        pump_high_z_o, reserved_zero_bit_o, pd_hardwire_o, pd_test_mode_o;
  logic        demod_gain_sel_o, demod_shift_sign_o;
  int          err_total = 0;
  int          checked = 0;
  int          cyc = 0;
  int          fb_n = 0;
  int          rf_n = 0;
  // Spare bit kept zero, mode select never mixed
  localparam logic [17:0] M_SW = 18'h171CF;
  localparam logic [17:0] M_HW = 18'h00F60;
  tml_host_model host (.serial_clock_o(serial_clock_i), .serial_data_o(serial_data_i),
    .load_strobe_o(load_strobe_i));
  tml_mode_latch uut (.clock_i, .rst_i, .serial_clock_i, .serial_data_i, .load_strobe_i,
    .chip_enable_i, .receive_shutdown_pin_i, .transmit_shutdown_pin_i, .synth_shutdown_pin_i,
    .prescaler_modulus_sel_o, .detector_polarity_sel_o, .pump_gain_sel_o,
    .pump_high_z_o, .reserved_zero_bit_o, .gp_out_o, .pd_hardwire_o, .pd_test_mode_o,
    .rx_chain_on_o, .tx_chain_on_o, .synth_on_o, .chip_on_o, .demod_gain_sel_o,
    .demod_shift_sign_o, .demod_shift_code_o, .mode_word_o, .divider_word_o,
    .feedback_load_o, .reference_load_o);
  always #2 clock_i = ~clock_i;
  // Count load pulses and cut a hung run short
  always @(posedge clock_i) begin
    fb_n += feedback_load_o;
    rf_n += reference_load_o;
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      close_out();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [17:0] got, input logic [17:0] exp);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
    end
  endtask
  // Power flags as {chip, synth, rx, tx}
  task automatic pw(input logic [3:0] exp);
    chk({14'h0, chip_on_o, synth_on_o, rx_chain_on_o, tx_chain_on_o}, {14'h0, exp});
  endtask
  // Decoded fields as {shift code, sign, demod gain, test, hardwire, spare, high-z, gain,
  // polarity, modulus}
  task automatic fields(input logic [12:0] exp);
    chk({5'h0, demod_shift_code_o, demod_shift_sign_o, demod_gain_sel_o, pd_test_mode_o,
         pd_hardwire_o, reserved_zero_bit_o, pump_high_z_o, pump_gain_sel_o,
         detector_polarity_sel_o, prescaler_modulus_sel_o}, {5'h0, exp});
  endtask
  // Outputs trail the pins by about five cycles; ten leaves margin
  task automatic settle;
    repeat (10) @(posedge clock_i);
    #1;
  endtask
  // Pins as {ce, rx, tx, pll}
  task automatic pins(input logic [3:0] v);
    @(posedge clock_i);
    {chip_enable_i, receive_shutdown_pin_i, transmit_shutdown_pin_i, synth_shutdown_pin_i} <= v;
    settle();
  endtask
  task automatic load(input logic [19:0] w, input logic do_load);
    host.send(w, do_load);
    settle();
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (6) @(posedge clock_i);
    rst_i <= 1'b0;
    settle();
    load({M_SW, 2'b11}, 1'b1);
    chk(mode_word_o, M_SW);
    chk({15'h0, gp_out_o}, 18'h00003);
    pw(4'hE);
    fields(13'h158F);
    $display("test software load done");
    load({18'h3FFFF, 2'b00}, 1'b1);
    chk(divider_word_o, 18'h3FFFF);
    load({18'h00155, 2'b10}, 1'b1);
    chk(mode_word_o, M_SW);
    chk(divider_word_o, 18'h00155);
    chk(18'(fb_n), 18'h00001);
    chk(18'(rf_n), 18'h00001);
    load({M_HW, 2'b01}, 1'b0);
    chk(mode_word_o, M_SW);
    host.strobe();
    settle();
    chk(mode_word_o, M_HW);
    chk({15'h0, gp_out_o}, 18'h00000);
    fields(13'h0020);
    $display("test divider and strobe done");
    pins(4'hC);
    pw(4'hE);
    pins(4'hB);
    pw(4'h9);
    pins(4'h6);
    pw(4'h0);
    chk(mode_word_o, M_HW);
    $display("test power pins done");
    close_out();
  end
endmodule
`default_nettype wire

//--- verif/tml_host_model.sv
// Host model that shifts words into the serial pins of the mode latch
`timescale 1ns/100ps
`default_nettype none
module tml_host_model (
  output logic serial_clock_o,
  output logic serial_data_o,
  output logic load_strobe_o
);
  // Link clock stands low outside frames
  initial begin
    serial_clock_o = 1'b0;
    serial_data_o  = 1'b0;
    load_strobe_o  = 1'b0;
  end
  ////////////////////////////////////////////////////////////////////////////
  // One frame of 20 bits at a 125 ns link period
  task automatic send(input logic [19:0] w, input logic do_load);
    // Uneven half periods and a half-step skew keep every pin change off the system clock edge
    #0.5;
    for (int i = 19; i >= 0; i--) begin
      serial_data_o = w[i];
      #62.3 serial_clock_o = 1'b1;
      #62.7 serial_clock_o = 1'b0;
    end
    // A released data line must not keep showing the last bit
    serial_data_o = ~serial_data_o;
    if (do_load) begin
      strobe();
    end
  endtask
  // Strobe well clear of the last clock rise, wider than the 50 ns minimum
  task automatic strobe;
    #62.3 load_strobe_o = 1'b1;
    #125 load_strobe_o = 1'b0;
  endtask
endmodule
`default_nettype wire

//--- verif/tml_mode_latch_monitor.sv
// Checker that ties the latch outputs to the pins and to each other
`timescale 1ns/100ps
`default_nettype none
module tml_mode_latch_monitor (
  input wire logic        clock_i,
  input wire logic        rst_i,
  input wire logic        load_strobe_i,
  input wire logic        chip_enable_i,
  input wire logic        receive_shutdown_pin_i,
  input wire logic        synth_shutdown_pin_i,
  input wire logic        prescaler_modulus_sel_o,
  input wire logic        pump_high_z_o,
  input wire logic [2:0]  gp_out_o,
  input wire logic        pd_hardwire_o,
  input wire logic        pd_test_mode_o,
  input wire logic        rx_chain_on_o,
  input wire logic        synth_on_o,
  input wire logic        chip_on_o,
  input wire logic [3:0]  demod_shift_code_o,
  input wire logic [17:0] mode_word_o,
  input wire logic        feedback_load_o,
  input wire logic        reference_load_o
);
  logic        strobe_q;
  logic [3:0]  age_q;
  wire logic [17:0] m = mode_word_o;
  wire logic   sw = !m[10] && !m[11];
  // Cycles since the strobe pin rose; saturates so idle time never wraps
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      strobe_q <= 1'b0;
      age_q    <= 4'hF;
    end else begin
      strobe_q <= load_strobe_i;
      age_q    <= (load_strobe_i && !strobe_q) ? 4'h0 : age_q + {3'h0, age_q != 4'hF};
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);
  // Decoded fields are judged only once the latch has settled
  sequence s_calm;
    $stable(mode_word_o) [*3];
  endsequence
  property p_hold; !$stable(mode_word_o) |-> age_q inside {[4'h2:4'h8]}; endproperty
  a_hold: assert property (p_hold) else $error("latch moved without strobe");
  property p_pump; s_calm |-> prescaler_modulus_sel_o == m[0] && pump_high_z_o == m[3]; endproperty
  a_pump: assert property (p_pump) else $error("pump field wrong");
  property p_shift; s_calm |-> demod_shift_code_o == {m[14], m[15], m[16], m[17]}; endproperty
  a_shift: assert property (p_shift) else $error("shift code wrong");
  property p_gp; s_calm |-> gp_out_o == {m[9] && sw, m[8] && sw, m[7]}; endproperty
  a_gp: assert property (p_gp) else $error("general outputs wrong");
  property p_pdm; s_calm |-> pd_hardwire_o == (m[10] && m[11]) && pd_test_mode_o == (m[10] ^ m[11]);
  endproperty
  a_pdm: assert property (p_pdm) else $error("power-down mode wrong");
  property p_load; (feedback_load_o || reference_load_o) |-> $stable(mode_word_o) ##1
    !(feedback_load_o || reference_load_o); endproperty
  a_load: assert property (p_load) else $error("divider load wrong");
  property p_off; (!chip_enable_i) [*8] |-> !chip_on_o && !rx_chain_on_o && !synth_on_o; endproperty
  a_off: assert property (p_off) else $error("chip not off");
  property p_pll; (chip_enable_i && synth_shutdown_pin_i) [*8] |-> chip_on_o && !synth_on_o;
  endproperty
  a_pll: assert property (p_pll) else $error("synth not stopped");
  property p_hw; (chip_enable_i && pd_hardwire_o && $stable(receive_shutdown_pin_i)) [*8] |->
    rx_chain_on_o == receive_shutdown_pin_i; endproperty
  a_hw: assert property (p_hw) else $error("rx ignores pin");
  property p_sw; (chip_enable_i && sw && $stable(mode_word_o)) [*8] |-> rx_chain_on_o == !m[5];
  endproperty
  a_sw: assert property (p_sw) else $error("rx ignores bit");
endmodule
bind tml_mode_latch tml_mode_latch_monitor mon (.clock_i, .rst_i, .load_strobe_i, .chip_enable_i,
  .receive_shutdown_pin_i, .synth_shutdown_pin_i, .prescaler_modulus_sel_o, .pump_high_z_o,
  .gp_out_o, .pd_hardwire_o, .pd_test_mode_o, .rx_chain_on_o, .synth_on_o, .chip_on_o,
  .demod_shift_code_o, .mode_word_o, .feedback_load_o, .reference_load_o);
`default_nettype wire
